// ===== hdl/irlc_lookup.sv
// channel lookup table address and entry decode
`timescale 1ns/100ps
`default_nettype none
module irlc_lookup
  import irlc_pkg::*;
(
  input  wire logic [ADDR_W-1:0] i_base,
  input  wire logic [DLCI_W-1:0] i_dlci,
  input  wire logic              i_size_sel,
  input  wire logic [DATA_W-1:0] i_entry,
  output logic      [ADDR_W-1:0] o_addr,
  output irlc_lkp_res_t          o_result
);
  logic [DLCI_W-1:0] dlci_eff;

  // small table honours only the low ten identifier bits
  always_comb
  begin
    dlci_eff = i_dlci;
    if (i_size_sel)
      dlci_eff[DLCI_W-1:DLCI_W_SMALL] = '0;
  end

  // one 16-bit word per identifier
  assign o_addr = i_base + {10'h000, dlci_eff, 1'b0};

  // flag in bit 0, context index in the top thirteen bits
  assign o_result.active    = i_entry[LKP_ACTIVE_BIT];
  assign o_result.ctx_index = i_entry[DATA_W-1:LKP_IDX_LO];
endmodule
`default_nettype wire

// ===== hdl/irlc_ring_ptr.sv
// base pointer and slot index of one interrupt ring
`timescale 1ns/100ps
`default_nettype none
module irlc_ring_ptr
  import irlc_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  input  wire logic              i_clear,
  input  wire logic              i_load_hi,
  input  wire logic              i_load_lo,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_advance,
  output logic      [ADDR_W-1:0] o_entry_addr,
  output logic      [IDX_W-1:0]  o_index
);
  logic [ADDR_W-1:0] base_q, base_d;
  logic [IDX_W-1:0]  idx_q, idx_d;

  // high word keeps only its low byte; upper byte is reserved zero
  always_comb
  begin
    base_d = base_q;
    idx_d  = idx_q;
    if (i_load_hi)
      base_d[ADDR_W-1:DATA_W] = i_data[ADDR_W-DATA_W-1:0];
    if (i_load_lo)
      base_d[DATA_W-1:0] = i_data;
    if (i_clear)
      idx_d = '0;
    else if (i_advance)
      idx_d = idx_q + 7'h01; // natural wrap 127 -> 0
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      base_q <= '0;
      idx_q  <= '0;
    end
    else
    begin
      base_q <= base_d;
      idx_q  <= idx_d;
    end
  end

  // two words per slot, so slots sit four bytes apart
  assign o_entry_addr = base_q + {15'h0000, idx_q, 2'b00};
  assign o_index      = idx_q;
endmodule
`default_nettype wire

// ===== hdl/irlc_top.sv
// interrupt ring writer and receive channel lookup engine
//
// Summary of operation
// - ring pointers are fetched from init block bytes 24 to 30
// - each interrupt ring has exactly 128 slots
// - slot is two words: context address, descriptor index, pending flag
// - receive disable suppresses receive entry and receive interrupt
// - transmit disable suppresses transmit entry and transmit interrupt
// - every written slot gets its pending flag set in bit 15
// - busy transmit slot: miss primitive 7 parameter 0, interrupt still given
// - busy receive slot: primitive 7 parameter 1, interrupt, frame discarded
// - transmit slot bits 14:8 hold current transmit descriptor index
// - receive slot bits 14:8 hold current receive descriptor index
// - transmit slot carries serviced context entry address
// - receive slot carries context entry address of received frame
// - lookup table covers 1024 or 8192 identifiers by size select
// - one 16-bit lookup word per channel identifier
// - only receive side reads the lookup table
// - inactive lookup entry means received data is ignored
// - context index comes from lookup bits 15:3
`timescale 1ns/100ps
`default_nettype none
module irlc_top
  import irlc_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_rst_b,
  input  wire logic [REG_A_W-1:0] i_reg_addr,
  input  wire logic [DATA_W-1:0]  i_reg_wdata,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  output logic      [DATA_W-1:0]  o_reg_rdata,
  output logic                    o_mem_req,
  output logic                    o_mem_we,
  output logic      [ADDR_W-1:0]  o_mem_addr,
  output logic      [DATA_W-1:0]  o_mem_wdata,
  input  wire logic               i_mem_ack,
  input  wire logic [DATA_W-1:0]  i_mem_rdata,
  input  wire logic               i_tx_valid,
  input  wire irlc_irq_req_t      i_tx_info,
  output logic                    o_tx_ready,
  input  wire logic               i_rx_valid,
  input  wire irlc_irq_req_t      i_rx_info,
  output logic                    o_rx_ready,
  input  wire logic               i_lkp_valid,
  input  wire logic [DLCI_W-1:0]  i_lkp_dlci,
  output logic                    o_lkp_ready,
  output logic                    o_lkp_done,
  output irlc_lkp_res_t           o_lkp_result,
  output logic                    o_rx_ignore,
  output logic                    o_tx_interrupt,
  output logic                    o_rx_interrupt,
  output logic                    o_rx_discard,
  output logic                    o_prim_valid,
  output irlc_prim_t              o_prim
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_q, rst_b;

  // assert at once, release two edges later
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_b      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_b      <= rst_meta_q;
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  logic [ADDR_W-1:0] init_base_q, init_base_d, lkp_base_q, lkp_base_d;
  logic              size_sel_q, size_sel_d, start;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              ptr_ok_q;
  irlc_state_t       state_q, state_d;
  logic [IDX_W-1:0]  tx_idx, rx_idx;

  // start is a write pulse and reads back as zero
  always_comb
  begin
    init_base_d = init_base_q;
    lkp_base_d  = lkp_base_q;
    size_sel_d  = size_sel_q;
    rdata_d     = '0;
    start       = 1'b0;
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        REG_CTRL:
        begin
          start      = i_reg_wdata[CTRL_START_BIT];
          size_sel_d = i_reg_wdata[CTRL_SIZE_BIT];
        end
        REG_INIT_HI: init_base_d[ADDR_W-1:DATA_W] = i_reg_wdata[ADDR_W-DATA_W-1:0];
        REG_INIT_LO: init_base_d[DATA_W-1:0] = i_reg_wdata;
        REG_LKP_HI:  lkp_base_d[ADDR_W-1:DATA_W] = i_reg_wdata[ADDR_W-DATA_W-1:0];
        REG_LKP_LO:  lkp_base_d[DATA_W-1:0] = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        REG_CTRL:     rdata_d[CTRL_SIZE_BIT] = size_sel_q;
        REG_INIT_HI:  rdata_d = {8'h00, init_base_q[ADDR_W-1:DATA_W]};
        REG_INIT_LO:  rdata_d = init_base_q[DATA_W-1:0];
        REG_LKP_HI:   rdata_d = {8'h00, lkp_base_q[ADDR_W-1:DATA_W]};
        REG_LKP_LO:   rdata_d = lkp_base_q[DATA_W-1:0];
        REG_STATUS:   rdata_d = {14'h0000, state_q != ST_IDLE, ptr_ok_q};
        REG_RING_IDX: rdata_d = {1'b0, tx_idx, 1'b0, rx_idx};
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      init_base_q <= '0;
      lkp_base_q  <= '0;
      size_sel_q  <= 1'b0;
      rdata_q     <= '0;
    end
    else
    begin
      init_base_q <= init_base_d;
      lkp_base_q  <= lkp_base_d;
      size_sel_q  <= size_sel_d;
      rdata_q     <= rdata_d;
    end
  end
  assign o_reg_rdata = rdata_q;

  // ************************************************************
  // rings and lookup decode
  // ************************************************************
  logic [1:0]        cnt_q, cnt_d;
  logic              cur_rx_q, cur_rx_d, tx_adv, rx_adv, ring_clr;
  logic [ADDR_W-1:0] tx_entry, rx_entry, cur_entry, lkp_addr;
  logic [DLCI_W-1:0] dlci_q, dlci_d;
  irlc_lkp_res_t     lkp_dec;

  // init words: tx high, tx low, rx high, rx low
  assign ring_clr = start && (state_q == ST_IDLE);

  irlc_ring_ptr u_tx_ring (
    .i_clock      (i_clock),
    .i_rst_b      (rst_b),
    .i_clear      (ring_clr),
    .i_load_hi    (state_q == ST_INIT && i_mem_ack && cnt_q == 2'h0),
    .i_load_lo    (state_q == ST_INIT && i_mem_ack && cnt_q == 2'h1),
    .i_data       (i_mem_rdata),
    .i_advance    (tx_adv),
    .o_entry_addr (tx_entry),
    .o_index      (tx_idx)
  );

  irlc_ring_ptr u_rx_ring (
    .i_clock      (i_clock),
    .i_rst_b      (rst_b),
    .i_clear      (ring_clr),
    .i_load_hi    (state_q == ST_INIT && i_mem_ack && cnt_q == 2'h2),
    .i_load_lo    (state_q == ST_INIT && i_mem_ack && cnt_q == INIT_LAST_WORD),
    .i_data       (i_mem_rdata),
    .i_advance    (rx_adv),
    .o_entry_addr (rx_entry),
    .o_index      (rx_idx)
  );

  irlc_lookup u_lookup (
    .i_base     (lkp_base_q),
    .i_dlci     ((state_q == ST_IDLE) ? i_lkp_dlci : dlci_q), // address valid at acceptance
    .i_size_sel (size_sel_q),
    .i_entry    (i_mem_rdata),
    .o_addr     (lkp_addr),
    .o_result   (lkp_dec)
  );

  assign cur_entry = cur_rx_q ? rx_entry : tx_entry;

  // ************************************************************
  // sequencer
  // ************************************************************
  irlc_irq_req_t cur_q, cur_d;
  irlc_prim_t    prim_q, prim_d;
  irlc_lkp_res_t lres_q, lres_d;
  logic ok_d, req_d, we_d, pv_d, txi_d, rxi_d, disc_d, done_d, ign_d;
  logic req_q, we_q, pv_q, txi_q, rxi_q, disc_q, done_q, ign_q;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic idle_ok;

  // lookup first: a frame must be resolved before its interrupt
  assign idle_ok     = (state_q == ST_IDLE) && ptr_ok_q && !start;
  assign o_lkp_ready = idle_ok;
  assign o_rx_ready  = idle_ok && !i_lkp_valid;
  assign o_tx_ready  = idle_ok && !i_lkp_valid && !i_rx_valid;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    cur_d = cur_q;
    cur_rx_d = cur_rx_q;
    dlci_d = dlci_q;
    ok_d = ptr_ok_q;
    prim_d = prim_q;
    lres_d = lres_q;
    {tx_adv, rx_adv, pv_d, txi_d, rxi_d, disc_d, done_d, ign_d} = '0;
    case (state_q)
      ST_IDLE:
      begin
        if (start)
        begin
          state_d = ST_INIT;
          cnt_d = '0;
          ok_d = 1'b0;
        end
        else if (o_lkp_ready && i_lkp_valid)
        begin
          dlci_d = i_lkp_dlci; // only the receive port feeds this
          state_d = ST_LKP;
        end
        else if (o_rx_ready && i_rx_valid)
        begin
          cur_d = i_rx_info;
          cur_rx_d = 1'b1;
          if (!i_rx_info.irq_disable) state_d = ST_CHK;
        end
        else if (o_tx_ready && i_tx_valid)
        begin
          cur_d = i_tx_info;
          cur_rx_d = 1'b0;
          if (!i_tx_info.irq_disable) state_d = ST_CHK;
        end
      end
      ST_INIT:
        if (i_mem_ack)
        begin
          cnt_d = cnt_q + 2'h1;
          if (cnt_q == INIT_LAST_WORD)
          begin
            state_d = ST_IDLE;
            ok_d = 1'b1;
          end
        end
      ST_CHK:
        if (i_mem_ack)
        begin
          if (i_mem_rdata[ENT_PEND_BIT])
          begin
            // slot not yet serviced: leave it, report the miss
            state_d = ST_IDLE;
            pv_d = 1'b1;
            prim_d.code = PRIM_MISS;
            prim_d.param = cur_rx_q ? PARAM_RX : PARAM_TX;
            txi_d = !cur_rx_q;
            rxi_d = cur_rx_q;
            disc_d = cur_rx_q;
          end
          else
            state_d = ST_W0;
        end
      ST_W0:
        if (i_mem_ack) state_d = ST_W1;
      ST_W1:
        if (i_mem_ack)
        begin
          state_d = ST_IDLE;
          tx_adv = !cur_rx_q;
          rx_adv = cur_rx_q;
          txi_d = !cur_rx_q;
          rxi_d = cur_rx_q;
        end
      ST_LKP:
        if (i_mem_ack)
        begin
          state_d = ST_IDLE;
          done_d = 1'b1;
          lres_d = lkp_dec;
          ign_d = !lkp_dec.active;
        end
      default: state_d = ST_IDLE;
    endcase

    // next memory access follows the next state; request holds until ack
    req_d = (state_d != ST_IDLE);
    we_d = (state_d == ST_W0) || (state_d == ST_W1);
    wdata_d = '0;
    case (state_d)
      ST_INIT: addr_d = init_base_q + INIT_PTR_OFS + {21'h000000, cnt_d, 1'b0};
      ST_CHK:  addr_d = cur_rx_d ? rx_entry : tx_entry; // ring picked in this very cycle
      ST_W0:
      begin
        addr_d = cur_entry;
        // pending flag, descriptor index, context high byte
        wdata_d = {1'b1, cur_d.desc_idx, cur_d.ctx_addr[ADDR_W-1:DATA_W]};
      end
      ST_W1:
      begin
        addr_d = cur_entry + ENTRY_W1_OFS;
        wdata_d = cur_d.ctx_addr[DATA_W-1:0];
      end
      ST_LKP:  addr_d = lkp_addr;
      default: addr_d = addr_q;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      {cnt_q, cur_rx_q, ptr_ok_q, req_q, we_q} <= '0;
      {pv_q, txi_q, rxi_q, disc_q, done_q, ign_q} <= '0;
      {cur_q, dlci_q, prim_q, lres_q, addr_q, wdata_q} <= '0;
    end
    else
    begin
      state_q <= state_d;
      {cnt_q, cur_rx_q, ptr_ok_q, req_q, we_q} <= {cnt_d, cur_rx_d, ok_d, req_d, we_d};
      {pv_q, txi_q, rxi_q, disc_q, done_q, ign_q} <= {pv_d, txi_d, rxi_d, disc_d, done_d, ign_d};
      {cur_q, dlci_q, prim_q, lres_q, addr_q, wdata_q} <=
        {cur_d, dlci_d, prim_d, lres_d, addr_d, wdata_d};
    end
  end

  assign o_mem_req      = req_q;
  assign o_mem_we       = we_q;
  assign o_mem_addr     = addr_q;
  assign o_mem_wdata    = wdata_q;
  assign o_prim_valid   = pv_q;
  assign o_prim         = prim_q;
  assign o_tx_interrupt = txi_q;
  assign o_rx_interrupt = rxi_q;
  assign o_rx_discard   = disc_q;
  assign o_lkp_done     = done_q;
  assign o_lkp_result   = lres_q;
  assign o_rx_ignore    = ign_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_b);

  a_init_fetch_range: assert property (
    (state_q == ST_INIT && req_q) |-> (addr_q - init_base_q) inside {[24:30]})
    else $error("pointer fetch outside init block words");
  a_slot_pend_idx: assert property (
    (state_q == ST_W0 && req_q) |-> we_q && wdata_q[ENT_PEND_BIT]
      && wdata_q[14:8] == cur_q.desc_idx && wdata_q[7:0] == cur_q.ctx_addr[23:16])
    else $error("slot first word malformed");
  a_slot_second_word: assert property (
    (state_q == ST_W1 && req_q) |-> addr_q == cur_entry + 24'h2
      && wdata_q == cur_q.ctx_addr[15:0])
    else $error("slot second word malformed");
  a_tx_miss_irq: assert property (
    (o_prim_valid && o_prim.param == PARAM_TX) |-> o_tx_interrupt && o_prim.code == 4'h7)
    else $error("tx miss without interrupt");
  a_rx_miss_drop: assert property (
    (o_prim_valid && o_prim.param == PARAM_RX) |-> o_rx_interrupt && o_rx_discard)
    else $error("rx miss without discard");
  a_rx_disable_quiet: assert property (
    (o_rx_ready && i_rx_valid && !i_lkp_valid && i_rx_info.irq_disable)
      |=> (!o_mem_req && !o_rx_interrupt) ##1 !o_rx_interrupt)
    else $error("disabled rx interrupt still queued");
  a_tx_disable_quiet: assert property (
    (o_tx_ready && i_tx_valid && i_tx_info.irq_disable)
      |=> (!o_mem_req && !o_tx_interrupt) ##1 !o_tx_interrupt)
    else $error("disabled tx interrupt still queued");
  a_ring_wrap: assert property (
    (tx_adv && tx_idx == IDX_LAST) |=> tx_idx == 7'h00)
    else $error("tx ring did not wrap");
  a_tx_no_lookup: assert property (
    (o_tx_ready && i_tx_valid) |=> state_q != ST_LKP)
    else $error("transmit path reached lookup");
  a_lookup_decode: assert property (
    (state_q == ST_LKP && i_mem_ack) |=> o_lkp_done
      && o_lkp_result.ctx_index == $past(i_mem_rdata[15:3])
      && o_rx_ignore == !$past(i_mem_rdata[0]))
    else $error("lookup result wrong");

  c_tx_written: cover property (tx_adv);
  c_rx_miss: cover property (o_rx_discard);
  c_lkp_inactive: cover property (o_rx_ignore);
endmodule
`default_nettype wire

// ===== shared/irlc_pkg.sv
// constants, states and carriers of the interrupt ring and channel lookup block
`default_nettype none
package irlc_pkg;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int ADDR_W    = 24;
  localparam int DATA_W    = 16;
  localparam int IDX_W     = 7;
  localparam int DLCI_W    = 13;
  localparam int CTX_IDX_W = 13;
  localparam int REG_A_W   = 4;
  localparam int CODE_W    = 4;

  // ************************************************************
  // memory layout
  // ************************************************************
  localparam logic [ADDR_W-1:0] INIT_PTR_OFS   = 24'h000018; // ring pointers at +24..+30
  localparam logic [1:0]        INIT_LAST_WORD = 2'h3;
  localparam logic [ADDR_W-1:0] ENTRY_W1_OFS   = 24'h000002;
  localparam int ENT_PEND_BIT   = 15;
  localparam int LKP_ACTIVE_BIT = 0;
  localparam int LKP_IDX_LO     = 3;
  localparam int DLCI_W_SMALL   = 10;
  localparam logic [IDX_W-1:0]  IDX_LAST = 7'h7f;

  // ************************************************************
  // provider primitive codes
  // ************************************************************
  localparam logic [CODE_W-1:0] PRIM_MISS = 4'h7;
  localparam logic [CODE_W-1:0] PARAM_TX  = 4'h0;
  localparam logic [CODE_W-1:0] PARAM_RX  = 4'h1;

  // ************************************************************
  // register port map
  // ************************************************************
  localparam logic [REG_A_W-1:0] REG_CTRL     = 4'h0;
  localparam logic [REG_A_W-1:0] REG_INIT_HI  = 4'h1;
  localparam logic [REG_A_W-1:0] REG_INIT_LO  = 4'h2;
  localparam logic [REG_A_W-1:0] REG_LKP_HI   = 4'h3;
  localparam logic [REG_A_W-1:0] REG_LKP_LO   = 4'h4;
  localparam logic [REG_A_W-1:0] REG_STATUS   = 4'h5;
  localparam logic [REG_A_W-1:0] REG_RING_IDX = 4'h6;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SIZE_BIT  = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_INIT = 3'h1,
    ST_CHK  = 3'h2,
    ST_W0   = 3'h3,
    ST_W1   = 3'h4,
    ST_LKP  = 3'h5
  } irlc_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] ctx_addr;
    logic [IDX_W-1:0]  desc_idx;
    logic              irq_disable;
  } irlc_irq_req_t;

  typedef struct packed {
    logic                 active;
    logic [CTX_IDX_W-1:0] ctx_index;
  } irlc_lkp_res_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] param;
  } irlc_prim_t;
endpackage
`default_nettype wire

// ===== testbench/irlc_mem_model.sv
// shared memory model answering the block's bus requests
`timescale 1ns/100ps
`default_nettype none
module irlc_mem_model
(
  input  wire logic        i_clock,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_slow,
  output logic             o_ack,
  output logic      [15:0] o_rdata
);
  // ************************************************************
  // word store, 64 kbyte window of the address space
  // ************************************************************
  logic [15:0] mem [0:32767];
  logic [1:0]  wait_q;

  initial
  begin
    o_ack   = 1'b0;
    o_rdata = 16'h0000;
    wait_q  = 2'h0;
  end

  // answer at once or after three idle cycles; outside an ack the data
  // lines toggle so a stale read never looks valid
  always @(posedge i_clock)
  begin
    o_rdata <= ~o_rdata;
    o_ack   <= 1'b0;
    if (o_ack || !i_req)
      wait_q <= 2'h0;
    else if (!i_slow || wait_q == 2'h3)
    begin
      o_ack <= 1'b1;
      if (i_we)
        mem[i_addr[15:1]] <= i_wdata;
      else
        o_rdata <= mem[i_addr[15:1]];
    end
    else
      wait_q <= wait_q + 2'h1;
  end
endmodule
`default_nettype wire

// ===== testbench/tb_interrupt_ring_and_channel_lookup.sv
// self-checking bench of the interrupt ring and channel lookup block
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_ring_and_channel_lookup
  import irlc_pkg::*;
;
  typedef struct {int k; logic [23:0] ctx; logic [6:0] idx; logic dis; logic pend;
    logic sz; logic [12:0] dl; logic [15:0] ent;} irlc_row_t;
  localparam logic [23:0] TXB = 24'h011000;
  localparam logic [23:0] RXB = 24'h022000;
  localparam logic [23:0] LKB = 24'h034000;
  logic          i_clock, i_rst_b, i_reg_wr, i_reg_rd, i_tx_valid, i_rx_valid, i_lkp_valid;
  logic          o_mem_req, o_mem_we, i_mem_ack, o_tx_ready, o_rx_ready, o_lkp_ready;
  logic          o_lkp_done, o_rx_ignore, o_tx_interrupt, o_rx_interrupt, o_rx_discard;
  logic          o_prim_valid, slow;
  logic [3:0]    i_reg_addr;
  logic [15:0]   i_reg_wdata, o_reg_rdata, i_mem_rdata, o_mem_wdata, rv;
  logic [23:0]   o_mem_addr, sa;
  logic [12:0]   i_lkp_dlci;
  logic [6:0]    txn, rxn;
  logic [5:0]    pl;
  logic [2:0]    rdy;
  irlc_irq_req_t i_tx_info;
  irlc_lkp_res_t o_lkp_result;
  irlc_prim_t    o_prim, prim_seen;
  int            err_total, comparisons, cyc, cnt [6], snap [6];
  irlc_row_t     rows [9];

  irlc_top dut (.i_clock, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack,
    .i_mem_rdata, .i_tx_valid, .i_tx_info, .o_tx_ready, .i_rx_valid,
    .i_rx_info(i_tx_info), .o_rx_ready, .i_lkp_valid, .i_lkp_dlci, .o_lkp_ready,
    .o_lkp_done, .o_lkp_result, .o_rx_ignore, .o_tx_interrupt, .o_rx_interrupt,
    .o_rx_discard, .o_prim_valid, .o_prim);
  irlc_mem_model mdl (.i_clock(i_clock), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_slow(slow), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata));

  assign pl  = {o_rx_ignore, o_rx_discard, o_prim_valid, o_lkp_done, o_rx_interrupt,
    o_tx_interrupt};
  assign rdy = {o_lkp_ready, o_rx_ready, o_tx_ready};

  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  // ************************************************************
  // pulse tally and hang limit
  // ************************************************************
  // one-cycle pulses are counted mid cycle, after the edge has settled
  always @(negedge i_clock)
  begin
    cyc++;
    for (int i = 0; i < 6; i++)
      if (pl[i] === 1'b1)
        cnt[i]++;
    if (o_prim_valid === 1'b1)
      prim_seen = o_prim;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    @(negedge i_clock);
    rv = o_reg_rdata;
  endtask

  // hold the request until an edge that sees ready high
  task automatic fire(input int k);
    @(posedge i_clock);
    i_tx_valid  <= (k == 0);
    i_rx_valid  <= (k == 1);
    i_lkp_valid <= (k == 2);
    for (int i = 0; i < 50; i++)
    begin
      @(negedge i_clock);
      if (rdy[k] === 1'b1)
        break;
    end
    @(posedge i_clock);
    {i_tx_valid, i_rx_valid, i_lkp_valid} <= 3'h0;
  endtask

  // one event: preset memory, send it, then judge slot, pulses and result
  task automatic run_row(input irlc_row_t r);
    sa = ((r.k == 0) ? TXB : RXB) + {15'h0, (r.k == 0) ? txn : rxn, 2'h0};
    if (r.k == 2)
    begin
      wr(REG_CTRL, {14'h0, r.sz, 1'b0});
      sa = LKB + {10'h0, r.sz ? {3'h0, r.dl[9:0]} : r.dl, 1'b0};
      mdl.mem[sa[15:1]] = r.ent;
    end
    else
    begin
      mdl.mem[sa[15:1]] = {r.pend, 15'h0};
      mdl.mem[sa[15:1] + 1] = 16'h5a5a;
    end
    snap = cnt;
    @(posedge i_clock);
    i_tx_info  <= '{r.ctx, r.idx, r.dis};
    i_lkp_dlci <= r.dl;
    slow       <= ~slow;
    fire(r.k);
    for (int i = 0; i < 40 && cnt == snap; i++)
      @(negedge i_clock);
    if (r.k == 2)
    begin
      chk("lookup_done", 24'h1, 24'(cnt[2] - snap[2]));
      chk("lookup_active", 24'(r.ent[0]), 24'(o_lkp_result.active));
      chk("lookup_index", 24'(r.ent[15:3]), 24'(o_lkp_result.ctx_index));
      chk("rx_ignore", 24'(!r.ent[0]), 24'(cnt[5] - snap[5]));
    end
    else if (r.dis)
    begin
      chk("irq_count", 24'h0, 24'(cnt[r.k] - snap[r.k]));
      chk("slot_word1", 24'h5a5a, 24'(mdl.mem[sa[15:1] + 1]));
    end
    else if (r.pend)
    begin
      chk("miss_prim", {16'h0, PRIM_MISS, r.k ? PARAM_RX : PARAM_TX}, 24'(prim_seen));
      chk("miss_irq", 24'h1, 24'(cnt[r.k] - snap[r.k]));
      chk("discard", 24'(r.k), 24'(cnt[4] - snap[4]));
      chk("slot_word1", 24'h5a5a, 24'(mdl.mem[sa[15:1] + 1]));
    end
    else
    begin
      chk("slot_word0", {8'h0, 1'b1, r.idx, r.ctx[23:16]}, 24'(mdl.mem[sa[15:1]]));
      chk("slot_word1", 24'(r.ctx[15:0]), 24'(mdl.mem[sa[15:1] + 1]));
      chk("irq_count", 24'h1, 24'(cnt[r.k] - snap[r.k]));
      if (r.k == 0)
        txn++;
      else
        rxn++;
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {i_rst_b, i_reg_wr, i_reg_rd, i_tx_valid, i_rx_valid, i_lkp_valid, slow} = 7'h0;
    {i_reg_addr, i_reg_wdata, i_lkp_dlci, txn, rxn} = '0;
    i_tx_info = '0;
    rows = '{'{0, 24'h9abcde, 7'h55, 1'b0, 1'b0, 1'b0, 13'h0, 16'h0},
      '{1, 24'h123456, 7'h7f, 1'b0, 1'b0, 1'b0, 13'h0, 16'h0},
      '{0, 24'h000001, 7'h01, 1'b0, 1'b1, 1'b0, 13'h0, 16'h0},
      '{1, 24'h000002, 7'h02, 1'b0, 1'b1, 1'b0, 13'h0, 16'h0},
      '{0, 24'h000003, 7'h03, 1'b1, 1'b0, 1'b0, 13'h0, 16'h0},
      '{1, 24'h000004, 7'h04, 1'b1, 1'b0, 1'b0, 13'h0, 16'h0},
      '{2, 24'h0, 7'h0, 1'b0, 1'b0, 1'b0, 13'h1fff, 16'hfff9},
      '{2, 24'h0, 7'h0, 1'b0, 1'b0, 1'b0, 13'h0005, 16'h0028},
      '{2, 24'h0, 7'h0, 1'b0, 1'b0, 1'b1, 13'h1c07, 16'h0011}};
    mdl.mem[15'h008c] = 16'h0001;
    mdl.mem[15'h008d] = 16'h1000;
    mdl.mem[15'h008e] = 16'h0002;
    mdl.mem[15'h008f] = 16'h2000;
    // busy tx slot 1 must not be mistaken for the first rx slot
    mdl.mem[TXB[15:1] + 15'h0002] = 16'h8000;
    repeat (12) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd(REG_RING_IDX);
    chk("ring_idx_reset", 24'h0, 24'(rv));
    rd(4'hf);
    chk("unmapped", 24'h0, 24'(rv));
    wr(REG_INIT_HI, 16'h0000);
    wr(REG_INIT_LO, 16'h0100);
    wr(REG_LKP_HI, 16'h0003);
    wr(REG_LKP_LO, 16'h4000);
    wr(REG_CTRL, 16'h0001);
    for (int i = 0; i < 40 && rv[0] !== 1'b1; i++)
      rd(REG_STATUS);
    chk("pointers_loaded", 24'h1, 24'(rv[0]));
    foreach (rows[i])
      run_row(rows[i]);
    // walk the transmit ring once round so slot zero is written again
    for (int i = 0; i < 129; i++)
      run_row('{0, 24'(i * 3), 7'(i), 1'b0, 1'b0, 1'b0, 13'h0, 16'h0});
    rd(REG_RING_IDX);
    chk("ring_idx", {8'h0, 1'b0, txn, 1'b0, rxn}, 24'(rv));
    rd(REG_CTRL);
    chk("size_select", 24'h2, 24'(rv));
    final_report();
  end
endmodule
`default_nettype wire
